/* File: pkg/node_cfg_pkg.sv */
// constants for the multidrop serial port configuration selector
package node_cfg_pkg;
	localparam int          ADDR_W        = 6;
	localparam int          RATE_CODE_W   = 2;
	localparam int          SW_W          = 8;
	localparam int          ADDR_LSB      = 0;
	localparam int          RATE_LSB      = 6;
	localparam int          RATE_SEL_W    = 32;
	localparam int          SETTLE_W      = 4;
	localparam logic [3:0]  SETTLE_CYCLES = 4'h8;
	localparam logic [5:0]  ADDR_ZERO     = 6'h00;
	localparam logic [1:0]  RATE_FROM_NVM = 2'h0;
	localparam logic [1:0]  RATE_CODE_9K6 = 2'h1;
	localparam logic [1:0]  RATE_CODE_38K = 2'h2;
	localparam logic [1:0]  RATE_CODE_115 = 2'h3;
	localparam logic [31:0] BPS_9K6       = 32'h0000_2580;
	localparam logic [31:0] BPS_38K4      = 32'h0000_9600;
	localparam logic [31:0] BPS_115K2     = 32'h0001_c200;
	typedef enum logic [2:0] {
		ST_SETTLE = 3'h1,
		ST_LATCH  = 3'h2,
		ST_HOLD   = 3'h4
	} load_state_t;
endpackage

/* File: pkg/cfg_sw_if.sv */
// switch fields passed from the decoder to the selector
`timescale 1ns/1ps
`default_nettype none
interface cfg_sw_if;
	logic [5:0] sw_addr;
	logic [1:0] sw_rate;
	modport dec (output sw_addr, output sw_rate);
	modport sel (input sw_addr, input sw_rate);
endinterface
`default_nettype wire

/* File: rtl/switch_field_split.sv */
// splits the eight switches into address and rate-code fields
`timescale 1ns/1ps
`default_nettype none
module switch_field_split
	import node_cfg_pkg::*;
(
	input  wire logic [SW_W-1:0] sw_in,
	cfg_sw_if.dec                fld
);
	// switch one lands in bit 0; on reads as 1
	assign fld.sw_addr = sw_in[ADDR_LSB +: ADDR_W];
	// switch seven lands in bit 0 of the code
	assign fld.sw_rate = sw_in[RATE_LSB +: RATE_CODE_W];
endmodule
`default_nettype wire

/* File: rtl/serial_node_config_select.sv */
// resolves the multidrop port node address and bit rate at start-up
`timescale 1ns/1ps
`default_nettype none
module serial_node_config_select
	import node_cfg_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic [SW_W-1:0]       sw_in,
	input  wire logic [ADDR_W-1:0]     nvm_addr,
	input  wire logic [RATE_SEL_W-1:0] nvm_bps,
	input  wire logic [ADDR_W-1:0]     p2p_nvm_addr,
	input  wire logic [RATE_SEL_W-1:0] p2p_nvm_bps,
	output logic [ADDR_W-1:0]          mdrop_addr,
	output logic [RATE_SEL_W-1:0]      mdrop_bps,
	output logic                       mdrop_cfg_valid,
	output logic [ADDR_W-1:0]          p2p_addr,
	output logic [RATE_SEL_W-1:0]      p2p_bps
);
	cfg_sw_if fld ();

	switch_field_split u_split (
		.sw_in (sw_in),
		.fld   (fld)
	);

	function automatic logic [RATE_SEL_W-1:0] code_to_bps(input logic [1:0] code,
		input logic [RATE_SEL_W-1:0] stored);
		case (code)
			RATE_CODE_9K6: code_to_bps = BPS_9K6;
			RATE_CODE_38K: code_to_bps = BPS_38K4;
			RATE_CODE_115: code_to_bps = BPS_115K2;
			default:       code_to_bps = stored;
		endcase
	endfunction

	load_state_t          state_reg;
	load_state_t          state_next;
	logic [SETTLE_W-1:0]  settle_reg;
	logic [ADDR_W-1:0]    addr_next;
	logic [RATE_SEL_W-1:0] bps_next;

	// switches may bounce right after power-up, so wait a few cycles first
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_SETTLE: begin
				if (settle_reg == SETTLE_CYCLES)
					state_next = ST_LATCH;
			end
			ST_LATCH: state_next = ST_HOLD;
			ST_HOLD:  state_next = ST_HOLD;
			default:  state_next = ST_SETTLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			state_reg <= ST_SETTLE;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			settle_reg <= '0;
		else if (state_reg == ST_SETTLE)
			settle_reg <= settle_reg + SETTLE_W'(1);
	end

	always_comb begin
		addr_next = (fld.sw_addr == ADDR_ZERO) ? nvm_addr : fld.sw_addr;
		bps_next  = code_to_bps(fld.sw_rate, nvm_bps);
	end

	// latched once; later switch moves are ignored until the next reset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mdrop_addr      <= ADDR_ZERO;
			mdrop_bps       <= '0;
			mdrop_cfg_valid <= 1'b0;
		end else if (state_reg == ST_LATCH) begin
			mdrop_addr      <= addr_next;
			mdrop_bps       <= bps_next;
			mdrop_cfg_valid <= 1'b1;
		end
	end

	// point-to-point settings never see the switches
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			p2p_addr <= ADDR_ZERO;
			p2p_bps  <= '0;
		end else begin
			p2p_addr <= p2p_nvm_addr;
			p2p_bps  <= p2p_nvm_bps;
		end
	end

	property p_addr_switch;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[5:0] != ADDR_ZERO) |=> (mdrop_addr == $past(sw_in[5:0]));
	endproperty
	a_addr_switch: assert property (p_addr_switch) else $error("address not from switches");

	property p_rate_code;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[7:6] == RATE_CODE_9K6) |=> (mdrop_bps == BPS_9K6);
	endproperty
	a_rate_code: assert property (p_rate_code) else $error("code 1 not 9.6 kbps");

	property p_addr_nvm;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[5:0] == ADDR_ZERO) |=> (mdrop_addr == $past(nvm_addr));
	endproperty
	a_addr_nvm: assert property (p_addr_nvm) else $error("zero address did not use stored one");

	property p_rate_nvm;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[7:6] == RATE_FROM_NVM) |=> (mdrop_bps == $past(nvm_bps));
	endproperty
	a_rate_nvm: assert property (p_rate_nvm) else $error("zero code did not use stored rate");

	property p_rate_fast;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[7:6] == RATE_CODE_115) |=> (mdrop_bps == BPS_115K2);
	endproperty
	a_rate_fast: assert property (p_rate_fast) else $error("code 3 not 115.2 kbps");

	property p_rate_mid;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[7:6] == RATE_CODE_38K) |=> (mdrop_bps == BPS_38K4);
	endproperty
	a_rate_mid: assert property (p_rate_mid) else $error("code 2 not 38.4 kbps");

	// sampled nrst keeps the release edge from comparing against reset values
	property p_p2p_pass;
		@(posedge ref_clk) disable iff (!nrst)
		nrst |=> (p2p_addr == $past(p2p_nvm_addr) && p2p_bps == $past(p2p_nvm_bps));
	endproperty
	a_p2p_pass: assert property (p_p2p_pass) else $error("point-to-point settings disturbed");

	property p_hold;
		@(posedge ref_clk) disable iff (!nrst)
		mdrop_cfg_valid |=> (mdrop_cfg_valid && $stable(mdrop_addr) && $stable(mdrop_bps));
	endproperty
	a_hold: assert property (p_hold) else $error("multidrop config changed after latch");

	property p_valid_time;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(nrst) ##0 1'b1 |-> ##[1:12] mdrop_cfg_valid;
	endproperty
	a_valid_time: assert property (p_valid_time) else $error("config valid too late after reset");

	property p_settle_len;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_SETTLE) |-> ##[1:10] (state_reg == ST_LATCH);
	endproperty
	a_settle_len: assert property (p_settle_len) else $error("latch too late");

	// nothing may show on the multidrop side before the one latch
	property p_valid_early;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg != ST_HOLD) |-> !mdrop_cfg_valid;
	endproperty
	a_valid_early: assert property (p_valid_early) else $error("config valid before latch");

	property p_idle_zero;
		@(posedge ref_clk) disable iff (!nrst)
		!mdrop_cfg_valid |-> (mdrop_addr == ADDR_ZERO && mdrop_bps == '0);
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("multidrop outputs not clear before latch");

	property p_valid_rise;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(mdrop_cfg_valid) |-> $past(state_reg == ST_LATCH);
	endproperty
	a_valid_rise: assert property (p_valid_rise) else $error("config valid rose without a latch");

	property p_latch_once;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH) |=> (state_reg == ST_HOLD);
	endproperty
	a_latch_once: assert property (p_latch_once) else $error("latch state did not move to hold");

	property p_state_onehot;
		@(posedge ref_clk) disable iff (!nrst)
		$onehot(state_reg);
	endproperty
	a_state_onehot: assert property (p_state_onehot) else $error("load state not one-hot");

	property p_settle_cap;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_SETTLE) |-> (settle_reg <= SETTLE_CYCLES);
	endproperty
	a_settle_cap: assert property (p_settle_cap) else $error("settle count overran");

	// each field falls back on its own; the other keeps the switch value
	property p_rate_only;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[RATE_LSB +: RATE_CODE_W] == RATE_FROM_NVM
			&& sw_in[ADDR_LSB +: ADDR_W] != ADDR_ZERO)
			|=> (mdrop_addr == $past(sw_in[ADDR_LSB +: ADDR_W]) && mdrop_bps == $past(nvm_bps));
	endproperty
	a_rate_only: assert property (p_rate_only) else $error("stored rate disturbed the switch address");

	property p_addr_only;
		@(posedge ref_clk) disable iff (!nrst)
		(state_reg == ST_LATCH && sw_in[ADDR_LSB +: ADDR_W] == ADDR_ZERO
			&& sw_in[RATE_LSB +: RATE_CODE_W] != RATE_FROM_NVM)
			|=> (mdrop_addr == $past(nvm_addr)
				&& (mdrop_bps == BPS_9K6 || mdrop_bps == BPS_38K4 || mdrop_bps == BPS_115K2));
	endproperty
	a_addr_only: assert property (p_addr_only) else $error("stored address disturbed the switch rate");

	c_latch_switch: cover property (@(posedge ref_clk) disable iff (!nrst)
		state_reg == ST_LATCH && sw_in[5:0] != ADDR_ZERO);
	c_latch_nvm: cover property (@(posedge ref_clk) disable iff (!nrst)
		state_reg == ST_LATCH && sw_in[5:0] == ADDR_ZERO && sw_in[7:6] == RATE_FROM_NVM);
	c_fast: cover property (@(posedge ref_clk) disable iff (!nrst)
		state_reg == ST_LATCH && sw_in[7:6] == RATE_CODE_115);
	c_valid_rise: cover property (@(posedge ref_clk) disable iff (!nrst)
		$rose(mdrop_cfg_valid));
	c_addr_only: cover property (@(posedge ref_clk) disable iff (!nrst)
		state_reg == ST_LATCH && sw_in[ADDR_LSB +: ADDR_W] == ADDR_ZERO && sw_in[RATE_LSB +: RATE_CODE_W] != RATE_FROM_NVM);
endmodule
`default_nettype wire

/* File: bench/mdrop_host_model.sv */
// multidrop host model that takes the port settings once they are valid
`timescale 1ns/1ps
`default_nettype none
module mdrop_host_model (
	input  wire logic        ref_clk,
	input  wire logic [5:0]  addr,
	input  wire logic [31:0] bps,
	input  wire logic        valid,
	output logic [5:0]       seen_addr,
	output logic [31:0]      seen_bps
);
	// the host only trusts settings while valid is high
	always_ff @(posedge ref_clk) begin
		if (valid) begin
			seen_addr <= addr;
			seen_bps <= bps;
		end
	end
endmodule
`default_nettype wire

/* File: bench/serial_node_config_select_tb.sv */
// self-checking bench for the multidrop configuration selector
`timescale 1ns/1ps
`default_nettype none
module serial_node_config_select_tb;
	import node_cfg_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  sw_in = 8'h00;
	logic [5:0]  nvm_addr = 6'h00, p2p_nvm_addr = 6'h00, mdrop_addr, p2p_addr, seen_addr, ea;
	logic [31:0] nvm_bps = 32'h0, p2p_nvm_bps = 32'h0, mdrop_bps, p2p_bps, seen_bps, eb;
	logic        mdrop_cfg_valid;
	logic [31:0] rng = 32'h644dda96;
	logic [7:0]  corner [6] = '{8'h00, 8'h3f, 8'h40, 8'h81, 8'hc1, 8'h01};
	int          fails = 0, checked = 0, cycles = 0;
	always #4 ref_clk = ~ref_clk;
	serial_node_config_select dut (.ref_clk(ref_clk), .nrst(nrst), .sw_in(sw_in), .nvm_addr(nvm_addr),
		.nvm_bps(nvm_bps), .p2p_nvm_addr(p2p_nvm_addr), .p2p_nvm_bps(p2p_nvm_bps), .mdrop_addr(mdrop_addr),
		.mdrop_bps(mdrop_bps), .mdrop_cfg_valid(mdrop_cfg_valid), .p2p_addr(p2p_addr), .p2p_bps(p2p_bps));
	mdrop_host_model host (.ref_clk(ref_clk), .addr(mdrop_addr), .bps(mdrop_bps), .valid(mdrop_cfg_valid),
		.seen_addr(seen_addr), .seen_bps(seen_bps));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	function automatic logic [31:0] exp_bps(input logic [1:0] code, input logic [31:0] stored);
		case (code)
			2'h1: return BPS_9K6;
			2'h2: return BPS_38K4;
			2'h3: return BPS_115K2;
			default: return stored;
		endcase
	endfunction
	function automatic logic [5:0] exp_addr(input logic [7:0] sw, input logic [5:0] stored);
		return (sw[5:0] == 6'h00) ? stored : sw[5:0];
	endfunction
	task automatic cmp_addr(input logic [5:0] got, input logic [5:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t addr got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bps(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t rate got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t valid got %b exp %b", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		checked++;
		if (got != exp) begin
			fails++;
			$display("BAD t=%0t latch cycles got %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// generous ceiling: 26 runs of about 20 cycles each
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			finish_test();
		end
	end
	task automatic run(input logic [7:0] sw);
		int n;
		@(posedge ref_clk);
		nrst <= 1'b0;
		sw_in <= sw;
		rng = xorshift(rng);
		nvm_addr <= rng[5:0];
		p2p_nvm_addr <= rng[13:8];
		nvm_bps <= rng;
		p2p_nvm_bps <= ~rng;
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		cmp_bit(mdrop_cfg_valid, 1'b0);
		cmp_addr(mdrop_addr, ADDR_ZERO);
		ea = exp_addr(sw, nvm_addr);
		eb = exp_bps(sw[7:6], nvm_bps);
		n = 0;
		while (mdrop_cfg_valid !== 1'b1 && n < 30) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		// settle edges 0..SETTLE_CYCLES, the last one entering latch, then the load edge
		cmp_cnt(n, int'(SETTLE_CYCLES) + 2);
		cmp_bit(mdrop_cfg_valid, 1'b1);
		@(posedge ref_clk);
		#1;
		cmp_addr(seen_addr, ea);
		cmp_bps(seen_bps, eb);
		cmp_addr(p2p_addr, p2p_nvm_addr);
		cmp_bps(p2p_bps, p2p_nvm_bps);
		@(posedge ref_clk);
		sw_in <= ~sw;
		nvm_addr <= ~nvm_addr;
		nvm_bps <= ~nvm_bps;
		repeat (3) @(posedge ref_clk);
		#1;
		// late switch moves must not reach the port
		cmp_addr(mdrop_addr, ea);
		cmp_bps(mdrop_bps, eb);
		cmp_bit(mdrop_cfg_valid, 1'b1);
		cmp_addr(p2p_addr, p2p_nvm_addr);
		cmp_bps(p2p_bps, p2p_nvm_bps);
		$display("test sw %h done", sw);
	endtask
	initial begin
		foreach (corner[i])
			run(corner[i]);
		repeat (20) begin
			rng = xorshift(rng);
			run(rng[7:0]);
		end
		finish_test();
	end
endmodule
`default_nettype wire
